/* File: src/cbts_core.sv */
// CAN bit timing, receiver and transmitter status flags, register port.
// Assumes fault counters, sleep state and buffer events from frame logic.
// Operation
// - Segment one is field plus one quanta
// - Segment two is field plus one quanta
// - Bit time is prescale plus one times quanta count
// - Bit timing writable only in soft reset
// - Receiver flags are read and write-one-clear
// - Clear works only once cause is gone
// - Resets clear receiver flags and hold them
// - Bus activity in sleep sets wakeup
// - Receive count above 96 sets warning
// - Transmit count above 96 sets warning
// - Receive count above 127 sets passive
// - Transmit count above 127 sets passive
// - Bus-off above 255, 128 recessive runs
// - Overrun sets flag until software clears
// - Message in foreground sets receive full
// - Receive full blocks buffer exchange
// - Enabled flags drive their interrupts
// - Interrupt enables held clear during soft reset
// - Abort acks read-only, empties write-one-clear
// - Abort ack set when message aborted
// - Clearing empty also clears abort ack
// - Soft reset aborts and resets registers
// - Empty set on sent or granted abort
`timescale 1ns/1ps
`include "cbts_defs.svh"
module cbts_core #(
    parameter int NUM_TX = 3            // Transmit buffers
) (
    input  wire logic                 sys_clk_i,     // 125 MHz clock
    input  wire logic                 reset_n_i,     // Async reset
    input  wire cbts_pkg::cbts_req_t  req_i,         // Register request
    output logic [7:0]                rdata_o,       // Read data
    input  wire logic [8:0]           rx_fault_count_i, // Receive count
    input  wire logic [8:0]           tx_fault_count_i, // Transmit count
    input  wire logic                 sleep_i,       // Internal sleep
    input  wire logic                 can_rx_i,      // Bus pin
    input  wire logic                 overrun_i,     // Overrun pulse
    input  wire logic                 bg_ready_i,    // Background full
    input  wire logic [NUM_TX-1:0]    tx_sent_i,     // Sent pulses
    input  wire logic [NUM_TX-1:0]    tx_aborted_i,  // Abort grants
    output logic                      exchange_o,    // Move bg to fg
    output logic                      soft_reset_o,  // Soft reset state
    output logic                      tq_tick_o,     // Quantum enable
    output logic                      bit_tick_o,    // Bit enable
    output logic                      sample_o,      // Sampled bus bit
    output cbts_pkg::cbts_irq_t       irq_o          // Interrupts
);

    logic                   soft_reset_ctl;
    cbts_pkg::cbts_timing_t bit_timing_1;
    logic [5:0]             prescale;
    cbts_pkg::cbts_rx_flags_t receiver_flags;
    logic [7:0]             receiver_irq_enables;
    logic [NUM_TX-1:0]      abort_ack_flag;
    logic [NUM_TX-1:0]      tx_buffer_empty_flag;
    logic                   rx_level;
    logic                   rx_level_d;
    logic [5:0]             pre_cnt;
    logic [4:0]             tq_cnt;
    logic [3:0]             rec_run;
    logic [7:0]             rec_seq;
    logic                   rx_warn_cond;
    logic                   tx_warn_cond;
    logic                   rx_pass_cond;
    logic                   tx_pass_cond;
    logic                   boff_cond;
    logic                   prev_rx_warn;
    logic                   prev_tx_warn;
    logic                   prev_rx_pass;
    logic                   prev_tx_pass;
    logic                   prev_boff;
    logic [7:0]             cause;
    logic [7:0]             clr;
    logic [7:0]             set;
    logic [7:0]             next_rx_flags;
    logic [4:0]             bit_len;
    logic                   wr_hit_rx;
    logic                   wr_hit_tx;

    // Bus pin through the synchroniser
    cbts_sync #(.RESET_VALUE(1'b1)) u_rx_sync (
        .sys_clk_i (sys_clk_i),
        .reset_n_i (reset_n_i),
        .pin_i     (can_rx_i),
        .level_o   (rx_level)
    );

    // Control bit; soft reset is entered at hard reset
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            soft_reset_ctl <= 1'(`CBTS_RST_CTRL);
        else if (req_i.wr && req_i.addr == `CBTS_OFS_CTRL)
            soft_reset_ctl <= req_i.wdata[`CBTS_CTRL_SOFT_RESET];
    end

    // Timing registers accept writes only in soft reset
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            bit_timing_1 <= `CBTS_RST_BIT_TIMING1;
            prescale     <= 6'(`CBTS_RST_PRESCALE);
        end
        else if (req_i.wr && soft_reset_ctl)
        begin
            if (req_i.addr == `CBTS_OFS_BIT_TIMING1)
                bit_timing_1 <= req_i.wdata;
            if (req_i.addr == `CBTS_OFS_PRESCALE)
                prescale <= req_i.wdata[5:0];
        end
    end

    // Quanta per bit: sync quantum plus both segments
    assign bit_len = 5'd1 + {1'b0, bit_timing_1.segment_one_len} + 5'd1
                   + {2'b00, bit_timing_1.segment_two_len} + 5'd1;

    // Prescaler to quantum tick, then quantum count to bit tick
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            pre_cnt    <= 6'h00;
            tq_cnt     <= 5'h00;
            tq_tick_o  <= 1'b0;
            bit_tick_o <= 1'b0;
        end
        else if (soft_reset_ctl)
        begin
            pre_cnt    <= 6'h00;
            tq_cnt     <= 5'h00;
            tq_tick_o  <= 1'b0;
            bit_tick_o <= 1'b0;
        end
        else
        begin
            tq_tick_o  <= 1'b0;
            bit_tick_o <= 1'b0;
            if (pre_cnt == prescale)
            begin
                pre_cnt   <= 6'h00;
                tq_tick_o <= 1'b1;
                if (tq_cnt == bit_len - 5'd1)
                begin
                    tq_cnt     <= 5'h00;
                    bit_tick_o <= 1'b1;
                end
                else
                    tq_cnt <= tq_cnt + 5'd1;
            end
            else
                pre_cnt <= pre_cnt + 6'd1;
        end
    end

    // Bus sample at bit end, edge memory for wakeup
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            sample_o   <= 1'b1;
            rx_level_d <= 1'b1;
        end
        else
        begin
            rx_level_d <= rx_level;
            if (bit_tick_o)
                sample_o <= rx_level;
        end
    end

    // Bus-off recovery: count runs of recessive bits
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            rec_run <= 4'h0;
            rec_seq <= 8'h00;
        end
        else if (!receiver_flags.bus_off_flag)
        begin
            rec_run <= 4'h0;
            rec_seq <= 8'h00;
        end
        else if (bit_tick_o)
        begin
            if (!rx_level)
                rec_run <= 4'h0;
            else if (rec_run == `CBTS_RECESSIVE_RUN - 4'd1)
            begin
                rec_run <= 4'h0;
                if (rec_seq != `CBTS_RECOVER_SEQ)
                    rec_seq <= rec_seq + 8'd1;
            end
            else
                rec_run <= rec_run + 4'd1;
        end
    end

    // Status conditions from the fault counters
    assign boff_cond    = tx_fault_count_i > `CBTS_BUS_OFF_LIMIT;
    assign rx_pass_cond = rx_fault_count_i > `CBTS_PASSIVE_LIMIT
                        && !receiver_flags.bus_off_flag;
    assign tx_pass_cond = tx_fault_count_i > `CBTS_PASSIVE_LIMIT
                        && !receiver_flags.bus_off_flag;
    assign rx_warn_cond = rx_fault_count_i > `CBTS_WARN_LIMIT
        && !receiver_flags.rx_passive_flag
        && !receiver_flags.tx_passive_flag
        && !receiver_flags.bus_off_flag;
    assign tx_warn_cond = tx_fault_count_i > `CBTS_WARN_LIMIT
        && !receiver_flags.rx_passive_flag
        && !receiver_flags.tx_passive_flag
        && !receiver_flags.bus_off_flag;

    // Previous condition levels for entry detection
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            prev_rx_warn <= 1'b0;
            prev_tx_warn <= 1'b0;
            prev_rx_pass <= 1'b0;
            prev_tx_pass <= 1'b0;
            prev_boff    <= 1'b0;
        end
        else
        begin
            prev_rx_warn <= rx_warn_cond;
            prev_tx_warn <= tx_warn_cond;
            prev_rx_pass <= rx_pass_cond;
            prev_tx_pass <= tx_pass_cond;
            prev_boff    <= boff_cond;
        end
    end

    // Set, cause and clear terms for the receiver flags
    always_comb
    begin
        set = 8'h00;
        set[`CBTS_RF_WAKEUP]  = sleep_i && rx_level_d && !rx_level;
        set[`CBTS_RF_RX_WARN] = rx_warn_cond && !prev_rx_warn;
        set[`CBTS_RF_TX_WARN] = tx_warn_cond && !prev_tx_warn;
        set[`CBTS_RF_RX_PASS] = rx_pass_cond && !prev_rx_pass;
        set[`CBTS_RF_TX_PASS] = tx_pass_cond && !prev_tx_pass;
        set[`CBTS_RF_BUS_OFF] = boff_cond && !prev_boff;
        set[`CBTS_RF_OVERRUN] = overrun_i;
        set[`CBTS_RF_RX_FULL] = bg_ready_i && !receiver_flags.receive_full_flag;
        cause = 8'h00;
        cause[`CBTS_RF_WAKEUP]  = sleep_i && !rx_level;
        cause[`CBTS_RF_RX_WARN] = rx_warn_cond;
        cause[`CBTS_RF_TX_WARN] = tx_warn_cond;
        cause[`CBTS_RF_RX_PASS] = rx_pass_cond;
        cause[`CBTS_RF_TX_PASS] = tx_pass_cond;
        cause[`CBTS_RF_BUS_OFF] = boff_cond
            || rec_seq != `CBTS_RECOVER_SEQ;
        cause[`CBTS_RF_OVERRUN] = overrun_i;
        cause[`CBTS_RF_RX_FULL] = 1'b0;
        wr_hit_rx = req_i.wr && req_i.addr == `CBTS_OFS_RX_FLAGS;
        clr = wr_hit_rx ? (req_i.wdata & ~cause) : 8'h00;
        next_rx_flags = (receiver_flags & ~clr) | set;
    end

    // Receiver flags, held clear during soft reset
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            receiver_flags <= 8'h00;
        else if (soft_reset_ctl)
            receiver_flags <= 8'h00;
        else
            receiver_flags <= next_rx_flags;
    end

    // Buffer exchange only while receive full is clear
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            exchange_o <= 1'b0;
        else
            exchange_o <= set[`CBTS_RF_RX_FULL] && !soft_reset_ctl;
    end

    // Receiver interrupt enables
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            receiver_irq_enables <= 8'h00;
        else if (soft_reset_ctl)
            receiver_irq_enables <= 8'h00;
        else if (req_i.wr && req_i.addr == `CBTS_OFS_RX_IRQ_EN)
            receiver_irq_enables <= req_i.wdata;
    end

    // Transmitter flags
    assign wr_hit_tx = req_i.wr && req_i.addr == `CBTS_OFS_TX_FLAGS;
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            tx_buffer_empty_flag <= '1;
            abort_ack_flag       <= '0;
        end
        else if (soft_reset_ctl)
        begin
            tx_buffer_empty_flag <= '1;
            abort_ack_flag       <= '0;
        end
        else
        begin
            for (int i = 0; i < NUM_TX; i++)
            begin
                if (tx_sent_i[i] || tx_aborted_i[i])
                begin
                    tx_buffer_empty_flag[i] <= 1'b1;
                    abort_ack_flag[i]       <= tx_aborted_i[i];
                end
                else if (wr_hit_tx && req_i.wdata[i])
                begin
                    tx_buffer_empty_flag[i] <= 1'b0;
                    abort_ack_flag[i]       <= 1'b0;
                end
            end
        end
    end

    // Interrupt outputs from flags and enables; transmit from the empty flags, masked during soft reset
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            irq_o <= '0;
        else
        begin
            irq_o.wakeup   <= receiver_flags.wakeup_flag
                            && receiver_irq_enables[`CBTS_RF_WAKEUP];
            irq_o.receive  <= receiver_flags.receive_full_flag
                            && receiver_irq_enables[`CBTS_RF_RX_FULL];
            irq_o.error    <= |(receiver_flags[7:1]
                            & receiver_irq_enables[7:1]
                            & 7'h3f);
            irq_o.transmit <= |tx_buffer_empty_flag && !soft_reset_ctl;
        end
    end

    // Soft reset state out
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            soft_reset_o <= 1'b1;
        else
            soft_reset_o <= soft_reset_ctl;
    end

    // Read data one cycle after the strobe
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            rdata_o <= 8'h00;
        else if (!req_i.rd)
            rdata_o <= 8'h00;
        else
            unique case (req_i.addr)
                `CBTS_OFS_CTRL:        rdata_o <= {7'h00, soft_reset_ctl};
                `CBTS_OFS_BIT_TIMING1: rdata_o <= bit_timing_1;
                `CBTS_OFS_RX_FLAGS:    rdata_o <= receiver_flags;
                `CBTS_OFS_RX_IRQ_EN:   rdata_o <= receiver_irq_enables;
                `CBTS_OFS_TX_FLAGS:    rdata_o <= {1'b0, abort_ack_flag,
                                                   1'b0, tx_buffer_empty_flag};
                `CBTS_OFS_PRESCALE:    rdata_o <= {2'b00, prescale};
                `CBTS_OFS_STATUS:      rdata_o <= {5'h00, sample_o,
                    bit_timing_1.segment_two_len < `CBTS_SEG2_MIN,
                    bit_timing_1.segment_one_len < `CBTS_SEG1_MIN};
                default:               rdata_o <= 8'h00;
            endcase
    end

    // Assertions
    AST_BT_LOCK: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        !soft_reset_ctl |=> $stable(bit_timing_1))
        else $error("Bit timing changed outside soft reset");
    AST_RF_HOLD: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        soft_reset_ctl |=> receiver_flags == 8'h00)
        else $error("Receiver flags not held in soft reset");
    AST_IE_HOLD: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        soft_reset_ctl |=> receiver_irq_enables == 8'h00)
        else $error("Enables not held in soft reset");
    AST_OVR_SET: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        overrun_i && !soft_reset_ctl |=> receiver_flags.overrun_flag)
        else $error("Overrun flag not set");
    AST_ZERO_WR: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        wr_hit_rx && req_i.wdata == 8'h00 && !soft_reset_ctl
        |=> (receiver_flags & $past(receiver_flags)) == $past(receiver_flags))
        else $error("Zero write cleared a flag");
    AST_CAUSE: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        wr_hit_rx && !soft_reset_ctl && boff_cond
        && receiver_flags.bus_off_flag |=> receiver_flags.bus_off_flag)
        else $error("Bus-off cleared while cause held");
    AST_EXCH: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        receiver_flags.receive_full_flag |=> !exchange_o)
        else $error("Exchange while receive full");
    AST_ABORT_ACK_FLAG: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        tx_aborted_i[0] && !soft_reset_ctl
        |=> abort_ack_flag[0] && tx_buffer_empty_flag[0])
        else $error("Abort ack not set");
    AST_TXCLR: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        !tx_buffer_empty_flag[0] |-> !abort_ack_flag[0])
        else $error("Abort ack without empty flag");
    CV_BOFF: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        receiver_flags.bus_off_flag);
    CV_RXF: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        exchange_o);
    CV_BIT: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        bit_tick_o);

endmodule : cbts_core

/* File: shared/cbts_defs.svh */
// Offsets, field positions, reset values and timing counts for the CAN
// bit-timing and status flag block.
// Assumes inclusion by name from the shared folder on the include path.
`ifndef CBTS_DEFS_SVH
`define CBTS_DEFS_SVH

// Register offsets on the plain register port
`define CBTS_OFS_CTRL        4'h0
`define CBTS_OFS_BIT_TIMING1 4'h1
`define CBTS_OFS_RX_FLAGS    4'h2
`define CBTS_OFS_RX_IRQ_EN   4'h3
`define CBTS_OFS_TX_FLAGS    4'h4
`define CBTS_OFS_PRESCALE    4'h5
`define CBTS_OFS_STATUS      4'h6

// Receiver flag bit positions
`define CBTS_RF_WAKEUP   7
`define CBTS_RF_RX_WARN  6
`define CBTS_RF_TX_WARN  5
`define CBTS_RF_RX_PASS  4
`define CBTS_RF_TX_PASS  3
`define CBTS_RF_BUS_OFF  2
`define CBTS_RF_OVERRUN  1
`define CBTS_RF_RX_FULL  0

// Control register bit positions
`define CBTS_CTRL_SOFT_RESET 0

// Reset values
`define CBTS_RST_CTRL        8'h01
`define CBTS_RST_BIT_TIMING1 8'h23
`define CBTS_RST_PRESCALE    8'h00

// Fault counter thresholds
`define CBTS_WARN_LIMIT    9'h060
`define CBTS_PASSIVE_LIMIT 9'h07f
`define CBTS_BUS_OFF_LIMIT 9'h0ff

// Bus-off recovery: sequences of recessive bits
`define CBTS_RECOVER_SEQ  8'h80
`define CBTS_RECESSIVE_RUN 4'hb

// Smallest legal segment field values
`define CBTS_SEG1_MIN 4'h3
`define CBTS_SEG2_MIN 3'h1

`endif

/* File: shared/cbts_pkg.sv */
// Types shared by the CAN bit-timing and status flag block.
// Assumes nothing of its surroundings.
package cbts_pkg;

    // Bit timing register layout
    typedef struct packed {
        logic       sample_three;
        logic [2:0] segment_two_len;
        logic [3:0] segment_one_len;
    } cbts_timing_t;

    // Receiver flag register layout
    typedef struct packed {
        logic wakeup_flag;
        logic rx_warning_flag;
        logic tx_warning_flag;
        logic rx_passive_flag;
        logic tx_passive_flag;
        logic bus_off_flag;
        logic overrun_flag;
        logic receive_full_flag;
    } cbts_rx_flags_t;

    // Register port request
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } cbts_req_t;

    // Interrupt outputs
    typedef struct packed {
        logic wakeup;
        logic receive;
        logic error;
        logic transmit;
    } cbts_irq_t;

endpackage : cbts_pkg

/* File: src/cbts_sync.sv */
// Three-stage synchroniser with agreement check for one pin input.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
module cbts_sync #(
    parameter logic RESET_VALUE = 1'b1
) (
    input  wire logic sys_clk_i,  // Module clock
    input  wire logic reset_n_i,  // Async reset, active low
    input  wire logic pin_i,      // Raw pin level
    output logic      level_o     // Filtered level
);

    logic stage1;
    logic stage2;
    logic stage3;

    // Sampling chain
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            stage1 <= RESET_VALUE;
            stage2 <= RESET_VALUE;
            stage3 <= RESET_VALUE;
        end
        else
        begin
            stage1 <= pin_i;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // Level changes only when the last two stages agree
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            level_o <= RESET_VALUE;
        else if (stage2 == stage3)
            level_o <= stage3;
    end

endmodule : cbts_sync

/* File: tb/cbts_bus_model.sv */
// Far CAN node model: drives the bus pin seen by the block.
// Assumes the bench pulses wake_i for one clock to send activity.
`timescale 1ns/1ps
module cbts_bus_model (
    input  wire logic sys_clk_i, // Module clock
    input  wire logic wake_i,    // Request a dominant pulse
    output logic      can_rx_o   // Bus level, 1 is recessive
);
    logic [3:0] left;
    // Recessive while idle, dominant while the pulse lasts
    initial left = 4'h0;
    always @(posedge sys_clk_i)
    begin
        if (wake_i)
            left <= 4'h6;
        else if (left != 4'h0)
            left <= left - 4'h1;
    end
    assign can_rx_o = (left == 4'h0);
endmodule : cbts_bus_model

/* File: tb/testbench.sv */
// Self-checking bench for the bit-timing and status flag block.
// Assumes the bus model is compiled before this file.
`timescale 1ns/1ps
module testbench;
    logic                sys_clk_i, reset_n_i, sleep, ovr, bg, wake;
    logic                rx_bus, exch, srst, tq, btick, smp;
    logic [8:0]          rx_fault_count, tx_fault_count;
    logic [2:0]          sent, abrt;
    logic [7:0]          rdata;
    cbts_pkg::cbts_req_t req;
    cbts_pkg::cbts_irq_t irq;
    int                  num_errors = 0, samples_checked = 0, exch_seen = 0;
    int                  cyc = 0;

    cbts_core cbts_core_i (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
        .req_i(req), .rdata_o(rdata), .rx_fault_count_i(rx_fault_count),
        .tx_fault_count_i(tx_fault_count), .sleep_i(sleep), .can_rx_i(rx_bus),
        .overrun_i(ovr), .bg_ready_i(bg), .tx_sent_i(sent),
        .tx_aborted_i(abrt), .exchange_o(exch), .soft_reset_o(srst),
        .tq_tick_o(tq), .bit_tick_o(btick), .sample_o(smp), .irq_o(irq));
    cbts_bus_model cbts_bus_model_i (.sys_clk_i(sys_clk_i), .wake_i(wake),
        .can_rx_o(rx_bus));

    // Clock and count of buffer exchanges
    initial
    begin
        sys_clk_i = 1'b0;
        forever #4 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i)
        if (exch === 1'b1) exch_seen <= exch_seen + 1;
    // Free cycle count for period checks
    always @(posedge sys_clk_i)
        cyc <= cyc + 1;

    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask : tick
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge sys_clk_i);
        req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk_i);
        req.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] e, input string s);
        @(posedge sys_clk_i);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk_i);
        req.rd <= 1'b0;
        #1 chk(s, e, rdata);
    endtask : rd
    task automatic stop_test;
        $display("Checked %0d, errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : stop_test

    // Reset values, unmapped read, timing writes only in soft reset
    task automatic t_regs;
        rd(4'h1, 8'h23, "timing reset");
        rd(4'h4, 8'h07, "tx flags reset");
        rd(4'hf, 8'h00, "unmapped");
        wr(4'h1, 8'h4a);
        rd(4'h1, 8'h4a, "timing write");
        wr(4'h0, 8'h00);
        wr(4'h1, 8'h12);
        rd(4'h1, 8'h4a, "timing locked");
    endtask : t_regs
    // Overrun flag, zero write, error interrupt, clear
    task automatic t_overrun;
        @(posedge sys_clk_i) ovr <= 1'b1;
        @(posedge sys_clk_i) ovr <= 1'b0;
        tick(2);
        wr(4'h2, 8'h00);
        rd(4'h2, 8'h02, "overrun set");
        wr(4'h3, 8'h02);
        tick(2);
        chk("error irq", 8'h01, {7'h0, irq.error});
        wr(4'h2, 8'h02);
        rd(4'h2, 8'h00, "overrun clear");
        tick(2);
        chk("error irq off", 8'h00, {7'h0, irq.error});
    endtask : t_overrun
    // Receive warning at the 96 boundary, clear refused while above
    task automatic t_warn;
        rx_fault_count <= 9'd96;
        tick(3);
        rd(4'h2, 8'h00, "at 96");
        rx_fault_count <= 9'd97;
        tick(3);
        wr(4'h2, 8'h40);
        rd(4'h2, 8'h40, "warn held");
        rx_fault_count <= 9'd0;
        tick(2);
        wr(4'h2, 8'h40);
        rd(4'h2, 8'h00, "warn clear");
    endtask : t_warn
    // Abort acknowledge, read-only bits, clearing empty clears ack
    task automatic t_abort;
        wr(4'h4, 8'h01);
        rd(4'h4, 8'h06, "empty clear");
        @(posedge sys_clk_i) abrt <= 3'h1;
        @(posedge sys_clk_i) abrt <= 3'h0;
        tick(2);
        wr(4'h4, 8'h70);
        rd(4'h4, 8'h17, "aborted");
        wr(4'h4, 8'h01);
        rd(4'h4, 8'h06, "ack cleared");
        @(posedge sys_clk_i) sent <= 3'h1;
        @(posedge sys_clk_i) sent <= 3'h0;
        tick(2);
        rd(4'h4, 8'h07, "sent");
        chk("tx irq", 8'h01, {7'h0, irq.transmit});
    endtask : t_abort
    // Receive full blocks a second exchange
    task automatic t_rxfull;
        wr(4'h3, 8'h01);
        @(posedge sys_clk_i) bg <= 1'b1;
        tick(8);
        bg <= 1'b0;
        chk("exchanges", 8'h01, 8'(exch_seen));
        rd(4'h2, 8'h01, "rx full");
        chk("rx irq", 8'h01, {7'h0, irq.receive});
        wr(4'h2, 8'h01);
        rd(4'h2, 8'h00, "rx released");
    endtask : t_rxfull
    // Wakeup in sleep, then soft reset clears and holds registers
    task automatic t_wake_soft;
        sleep <= 1'b1;
        wr(4'h3, 8'h80);
        @(posedge sys_clk_i) wake <= 1'b1;
        @(posedge sys_clk_i) wake <= 1'b0;
        tick(12);
        rd(4'h2, 8'h80, "wakeup");
        chk("wake irq", 8'h01, {7'h0, irq.wakeup});
        sleep <= 1'b0;
        wr(4'h0, 8'h01);
        rd(4'h2, 8'h00, "flags soft");
        chk("tx irq soft", 8'h00, {7'h0, irq.transmit});
        wr(4'h3, 8'hff);
        rd(4'h3, 8'h00, "enables soft");
    endtask : t_wake_soft

    // Fault thresholds, bus-off hold and recovery on a short bit
    task automatic t_boff;
        wr(4'h1, 8'h02);
        wr(4'h0, 8'h00);
        tx_fault_count <= 9'd97;
        tick(3);
        rd(4'h2, 8'h20, "tx warn");
        tx_fault_count <= 9'd200;
        tick(3);
        rd(4'h2, 8'h28, "tx passive");
        tx_fault_count <= 9'd300;
        rx_fault_count <= 9'd200;
        tick(3);
        rd(4'h2, 8'h3c, "bus off");
        wr(4'h2, 8'h3c);
        rd(4'h2, 8'h04, "bus off held");
        {rx_fault_count, tx_fault_count} <= '0;
        wr(4'h2, 8'h04);
        rd(4'h2, 8'h04, "recovery pending");
        tick(7100);
        wr(4'h2, 8'h04);
        rd(4'h2, 8'h00, "recovered");
    endtask : t_boff
    // Segment validity, quantum and bit periods, soft reset output
    task automatic t_bits;
        int t0;
        wr(4'h0, 8'h01);
        rd(4'h6, 8'h07, "status invalid");
        wr(4'h1, 8'h4a);
        wr(4'h5, 8'h01);
        rd(4'h6, 8'h04, "status valid");
        wr(4'h0, 8'h00);
        tick(2);
        chk("soft reset out", 8'h00, {7'h0, srst});
        @(posedge tq) #1 t0 = cyc;
        @(posedge tq) #1 chk("quantum", 8'h02, 8'(cyc - t0));
        @(posedge btick) #1 t0 = cyc;
        @(posedge btick) #1 chk("bit", 8'h22, 8'(cyc - t0));
        chk("sample", 8'h01, {7'h0, smp});
    endtask : t_bits

    // Main sequence
    initial
    begin
        {reset_n_i, sleep, ovr, bg, wake, rx_fault_count, tx_fault_count, sent, abrt} = '0;
        req = '0;
        repeat (2) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        t_regs();
        t_overrun();
        t_warn();
        t_abort();
        t_rxfull();
        t_wake_soft();
        t_boff();
        t_bits();
        stop_test();
    end
    // Watchdog well beyond the run length
    initial
    begin
        #100000;
        num_errors++;
        stop_test();
    end
endmodule : testbench
